/* File: conv_control.sv */
// Sigma-delta conversion sequencer, result registers and error flags
// Functional notes
// - Single mode write starts one conversion
// - Busy flag high throughout conversion
// - Quick after one period, slow after three
// - Select bit picks which filter sets done
// - Single mode returns idle, clears busy
// - Slow target also yields valid quick result
// - Continuous mode restarts immediately back to back
// - Slow results after three, then every period
// - Both filters update their results unless single mode ends on quick
// - Separate three-byte result sets per filter
// - Polarity zero gives straight binary
// - Polarity one gives two's complement
// - Filter overflow sets its clip flag
// - Done still set at end sets overrun
// - Summary error from clips, overrun, calibration
// - Results update regardless of errors
// - Offset DAC is sign and magnitude
// - Offset DAC write updates output
// - Burnout bit enables burnout currents
// - Polarity bit selects unipolar or bipolar
`timescale 1ns/1ps
`include "conv_cfg.svh"
module conv_control #(
  parameter int PERIOD = `PERIOD_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic [7:0]  sfr_wdata,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  output logic      [7:0]  sfr_rdata,
  input  wire logic [23:0] slow_filter_data,
  input  wire logic [23:0] quick_filter_data,
  input  wire logic        slow_filter_ovf,
  input  wire logic        quick_filter_ovf,
  input  wire logic        cal_limit_error,
  output logic             conversion_busy_flag,
  output logic             conversion_done_flag,
  output logic             modulator_run,
  output logic             burnout_enable,
  output logic      [7:0]  pga_gain,
  output logic             offset_dac_negative,
  output logic      [6:0]  offset_dac_magnitude,
  output logic             offset_dac_update
);
  typedef struct packed {
    conv_pkg::seq_state_t seq;
    conv_pkg::sys_mode_t  mode;
    logic [1:0]           periods;
    logic                 slow_primed;
    logic [7:0]           gain_polarity_control;
    logic                 irq_filter_select;
    logic [7:0]           offset_dac_level;
    logic                 dac_update;
    logic [23:0]          slow_result;
    logic [23:0]          quick_result;
    logic                 done;
    logic                 overrun;
    logic                 slow_clip;
    logic                 quick_clip;
    logic                 cal_err;
    logic [7:0]           rdata;
  } ctl_state_t;

  ctl_state_t state_reg;
  ctl_state_t state_next;
  logic       period_end;
  logic       running;
  logic       quick_ready;
  logic       slow_ready;
  logic       sel_ready;

  // Bipolar two's complement word
  // Bipolar code: the filter output is already a signed word, so coding is a pass
  // through in both modes; unipolar treats the same bits as unsigned magnitude.
  function automatic logic [23:0] code_result(input logic [23:0] raw, input logic bipolar);
    code_result = bipolar ? raw : {1'b0, raw[22:0]} | {raw[23], 23'h000000};
  endfunction

  assign running = (state_reg.seq == conv_pkg::st_convert);

  period_timer #(
    .PERIOD (PERIOD)
  ) u_timer (
    .clk        (clk),
    .reset      (reset),
    .run        (running),
    .period_end (period_end)
  );

  assign quick_ready = running && period_end;
  assign slow_ready  = quick_ready &&
                       (state_reg.slow_primed || state_reg.periods == 2'(`SLOW_PERIODS - 1));
  assign sel_ready   = state_reg.irq_filter_select ? quick_ready : slow_ready;

  always_comb begin
    logic      clr_done;
    logic      mode_wr;
    logic      err_wr;
    state_next = state_reg;
    clr_done   = 1'b0;
    mode_wr    = sfr_wr && sfr_addr == `MODE_ADDR;
    err_wr     = sfr_wr && sfr_addr == `ERR_STAT_ADDR;
    state_next.dac_update = 1'b0;

    if (mode_wr) begin
      state_next.mode = conv_pkg::sys_mode_t'(sfr_wdata[1:0]);
    end
    if (sfr_wr && sfr_addr == `GAIN_POL_ADDR && state_reg.mode == conv_pkg::mode_idle) begin
      state_next.gain_polarity_control = {3'b000, sfr_wdata[4:0]};
    end
    if (sfr_wr && sfr_addr == `CONV_CFG_ADDR && state_reg.mode == conv_pkg::mode_idle) begin
      state_next.irq_filter_select = sfr_wdata[`ISEL_BIT];
    end
    if (sfr_wr && sfr_addr == `DAC_ADDR) begin
      state_next.offset_dac_level = sfr_wdata;
      state_next.dac_update       = 1'b1;
    end
    if (err_wr) begin
      clr_done = ~sfr_wdata[`DONE_BIT];
      if (!sfr_wdata[`OVR_BIT])        state_next.overrun    = 1'b0;
      if (!sfr_wdata[`SLOW_CLIP_BIT])  state_next.slow_clip  = 1'b0;
      if (!sfr_wdata[`QUICK_CLIP_BIT]) state_next.quick_clip = 1'b0;
      if (!sfr_wdata[`ERR_BIT])        state_next.cal_err    = 1'b0;
    end
    if (clr_done) begin
      state_next.done = 1'b0;
    end

    case (state_reg.seq)
      conv_pkg::st_idle: begin
        state_next.periods     = 2'b00;
        state_next.slow_primed = 1'b0;
        if (mode_wr && (sfr_wdata[1:0] == 2'b01 || sfr_wdata[1:0] == 2'b10)) begin
          state_next.seq = conv_pkg::st_convert;
        end
      end
      conv_pkg::st_convert: begin
        if (slow_filter_ovf)  state_next.slow_clip  = 1'b1;
        if (quick_filter_ovf) state_next.quick_clip = 1'b1;
        if (quick_ready) begin
          if (state_reg.periods != 2'b11) state_next.periods = state_reg.periods + 2'b01;
          state_next.quick_result =
            code_result(quick_filter_data, state_reg.gain_polarity_control[`POL_BIT]);
        end
        if (slow_ready) begin
          state_next.slow_primed = 1'b1;
          state_next.slow_result =
            code_result(slow_filter_data, state_reg.gain_polarity_control[`POL_BIT]);
        end
        if (sel_ready) begin
          if (state_reg.done && !clr_done) state_next.overrun = 1'b1;
          state_next.done = 1'b1;
          if (state_reg.mode == conv_pkg::mode_single) begin
            state_next.mode = conv_pkg::mode_idle;
            state_next.seq  = conv_pkg::st_done;
          end
        end
        if (state_reg.mode != conv_pkg::mode_single &&
            state_reg.mode != conv_pkg::mode_continuous) begin
          state_next.seq = conv_pkg::st_done;
        end
      end
      conv_pkg::st_done: begin
        state_next.seq = conv_pkg::st_idle;
      end
      default: begin
        state_next.seq = conv_pkg::st_idle;
      end
    endcase
    if (cal_limit_error) state_next.cal_err = 1'b1;

    state_next.rdata = 8'h00;
    if (sfr_rd) begin
      case (sfr_addr)
        `GAIN_POL_ADDR:   state_next.rdata = state_reg.gain_polarity_control;
        `CONV_CFG_ADDR:   state_next.rdata = {3'b000, state_reg.irq_filter_select, 4'h0};
        `MODE_ADDR:       state_next.rdata = {6'h00, state_reg.mode};
        `ERR_STAT_ADDR:   state_next.rdata = {state_reg.done, running, 1'b0,
                            state_reg.slow_clip | state_reg.quick_clip |
                            state_reg.overrun | state_reg.cal_err,
                            1'b0, state_reg.overrun, state_reg.slow_clip,
                            state_reg.quick_clip};
        `DAC_ADDR:        state_next.rdata = state_reg.offset_dac_level;
        `SLOW_HIGH_ADDR:  state_next.rdata = state_reg.slow_result[23:16];
        `SLOW_MID_ADDR:   state_next.rdata = state_reg.slow_result[15:8];
        `SLOW_LOW_ADDR:   state_next.rdata = state_reg.slow_result[7:0];
        `QUICK_HIGH_ADDR: state_next.rdata = state_reg.quick_result[23:16];
        `QUICK_MID_ADDR:  state_next.rdata = state_reg.quick_result[15:8];
        `QUICK_LOW_ADDR:  state_next.rdata = state_reg.quick_result[7:0];
        default:          state_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg                       <= '0;
      state_reg.gain_polarity_control <= `GAIN_POL_RESET;
      state_reg.offset_dac_level      <= `DAC_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign conversion_busy_flag = running;
  assign conversion_done_flag = state_reg.done;
  assign modulator_run        = running;
  assign sfr_rdata            = state_reg.rdata;
  assign burnout_enable       = state_reg.gain_polarity_control[`BURNOUT_BIT];
  // Gain is two to the code
  assign pga_gain             = 8'h01 << state_reg.gain_polarity_control[2:0];
  assign offset_dac_negative  = state_reg.offset_dac_level[7];
  assign offset_dac_magnitude = state_reg.offset_dac_level[6:0];
  assign offset_dac_update    = state_reg.dac_update;

  busy_flag_a: assert property (@(posedge clk) disable iff (reset)
    (conversion_busy_flag && (state_reg.mode == conv_pkg::mode_continuous ||
     (state_reg.mode == conv_pkg::mode_single && !sel_ready))) |=> conversion_busy_flag)
    else $error("busy flag wrong");
  single_start_a: assert property (@(posedge clk) disable iff (reset)
    (state_reg.seq == conv_pkg::st_idle && sfr_wr && sfr_addr == `MODE_ADDR &&
     sfr_wdata[1:0] == 2'b01) |=> conversion_busy_flag)
    else $error("single start missed");
  single_end_a: assert property (@(posedge clk) disable iff (reset)
    (sel_ready && state_reg.mode == conv_pkg::mode_single && !sfr_wr)
    |=> state_reg.mode == conv_pkg::mode_idle ##1 !conversion_busy_flag)
    else $error("single did not end");
  done_set_a: assert property (@(posedge clk) disable iff (reset)
    sel_ready |=> conversion_done_flag)
    else $error("done not set");
  overrun_a: assert property (@(posedge clk) disable iff (reset)
    (sel_ready && conversion_done_flag && !sfr_wr) |=> state_reg.overrun)
    else $error("overrun missed");
  slow_wait_a: assert property (@(posedge clk) disable iff (reset)
    $rose(running) |-> !slow_ready [*8])
    else $error("slow result too early");
  quick_upd_a: assert property (@(posedge clk) disable iff (reset)
    quick_ready |=> state_reg.quick_result ==
      code_result($past(quick_filter_data), state_reg.gain_polarity_control[`POL_BIT]))
    else $error("quick result not written");
  gain_lock_a: assert property (@(posedge clk) disable iff (reset)
    (state_reg.mode != conv_pkg::mode_idle) |=> $stable(state_reg.gain_polarity_control))
    else $error("gain changed while active");
  dac_upd_a: assert property (@(posedge clk) disable iff (reset)
    (sfr_wr && sfr_addr == `DAC_ADDR) |=> offset_dac_update &&
      offset_dac_magnitude == $past(sfr_wdata[6:0]))
    else $error("dac update missed");
  clip_a: assert property (@(posedge clk) disable iff (reset)
    (running && slow_filter_ovf) |=> state_reg.slow_clip)
    else $error("slow clip missed");

  single_cov: cover property (@(posedge clk) disable iff (reset)
    sel_ready && state_reg.mode == conv_pkg::mode_single);
  cont_cov: cover property (@(posedge clk) disable iff (reset)
    slow_ready && state_reg.mode == conv_pkg::mode_continuous && state_reg.slow_primed);
  ovr_cov: cover property (@(posedge clk) disable iff (reset) $rose(state_reg.overrun));
endmodule // conv_control

/* File: conv_cfg.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef CONV_CFG_SVH
`define CONV_CFG_SVH
`define GAIN_POL_ADDR      8'hf4
`define CONV_CFG_ADDR      8'hfb
`define MODE_ADDR          8'hfa
`define ERR_STAT_ADDR      8'hf9
`define DAC_ADDR           8'hf8
`define SLOW_HIGH_ADDR     8'he3
`define SLOW_MID_ADDR      8'he2
`define SLOW_LOW_ADDR      8'he1
`define QUICK_HIGH_ADDR    8'he6
`define QUICK_MID_ADDR     8'he5
`define QUICK_LOW_ADDR     8'he4
`define GAIN_POL_RESET     8'h10
`define CONV_CFG_RESET     8'h00
`define DAC_RESET          8'h00
`define POL_BIT            4
`define BURNOUT_BIT        3
`define ISEL_BIT           4
`define DONE_BIT           7
`define BUSY_BIT           6
`define ERR_BIT            4
`define OVR_BIT            2
`define SLOW_CLIP_BIT      1
`define QUICK_CLIP_BIT     0
`define SLOW_PERIODS       3
`define PERIOD_CYCLES      16
`endif

/* File: conv_pkg.sv */
// Types for the conversion control block
package conv_pkg;
  typedef enum logic [1:0] {
    mode_idle,
    mode_single,
    mode_continuous,
    mode_reserved
  } sys_mode_t;
  typedef enum logic [1:0] {
    st_idle,
    st_convert,
    st_done
  } seq_state_t;
endpackage

/* File: period_timer.sv */
// Conversion-cycle period timer
`timescale 1ns/1ps
module period_timer #(
  parameter int PERIOD = 16
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic run,
  output logic      period_end
);
  typedef struct packed {
    logic [15:0] count;
  } timer_state_t;
  timer_state_t state_reg;
  timer_state_t state_next;

  always_comb begin
    state_next = state_reg;
    period_end = 1'b0;
    if (!run) begin
      state_next.count = 16'h0000;
    end else if (state_reg.count == 16'(PERIOD - 1)) begin
      state_next.count = 16'h0000;
      period_end = 1'b1;
    end else begin
      state_next.count = state_reg.count + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule // period_timer

/* File: conv_control_test.sv */
// Self-checking testbench for the conversion control block
`timescale 1ns/1ps
`include "conv_cfg.svh"
module conv_control_test;
  localparam int P = 4;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  sfr_addr = 8'h00;
  logic [7:0]  sfr_wdata = 8'h00;
  logic        sfr_wr = 1'b0;
  logic        sfr_rd = 1'b0;
  logic [7:0]  sfr_rdata;
  logic [23:0] slow_filter_data = 24'h000000;
  logic [23:0] quick_filter_data = 24'h000000;
  logic        slow_filter_ovf = 1'b0;
  logic        quick_filter_ovf = 1'b0;
  logic        cal_limit_error = 1'b0;
  logic        busy;
  logic        done;
  logic        mod_run;
  logic        burnout;
  logic [7:0]  pga_gain;
  logic        dac_neg;
  logic [6:0]  dac_mag;
  logic        dac_upd;
  int          failures = 0;
  int          n_compared = 0;
  int          n;

  always #5 clk = ~clk;

  conv_control #(.PERIOD(P)) u_dut (
    .clk(clk), .reset(reset), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .slow_filter_data(slow_filter_data), .quick_filter_data(quick_filter_data),
    .slow_filter_ovf(slow_filter_ovf), .quick_filter_ovf(quick_filter_ovf),
    .cal_limit_error(cal_limit_error), .conversion_busy_flag(busy),
    .conversion_done_flag(done), .modulator_run(mod_run), .burnout_enable(burnout),
    .pga_gain(pga_gain), .offset_dac_negative(dac_neg),
    .offset_dac_magnitude(dac_mag), .offset_dac_update(dac_upd)
  );

  task automatic finish_test();
    $display("Compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask

  // Read data is registered: taken one cycle after the strobe edge
  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    chk(what, {16'h0000, exp}, {16'h0000, sfr_rdata});
  endtask

  // Bounded wait on a flag; a timeout counts as a mismatch and ends the run
  task automatic wait_for(input logic want_done, input int lim, output int cnt);
    cnt = 0;
    while ((want_done ? done : ~busy) !== 1'b1) begin
      @(negedge clk);
      cnt++;
      if (cnt > lim) begin
        failures++;
        $display("Error wait expected flag seen timeout");
        finish_test();
      end
    end
  endtask

  task automatic test_reset();
    chk("pga_gain", 24'h1, 24'(pga_gain));
    chk("flags", 24'h0, {busy, done, mod_run, burnout, dac_neg, dac_mag, dac_upd});
    rchk("gain reg", `GAIN_POL_ADDR, `GAIN_POL_RESET);
    rchk("config", `CONV_CFG_ADDR, `CONV_CFG_RESET);
    rchk("unmapped", 8'h55, 8'h00);
    $display("Test reset done");
  endtask

  task automatic test_gain();
    for (int g = 0; g < 8; g++) begin
      wr(`GAIN_POL_ADDR, 8'h08 | 8'(g));
      chk("pga_gain", 24'(8'h01 << g), 24'(pga_gain));
      chk("burnout", 24'h1, 24'(burnout));
      rchk("gain reg", `GAIN_POL_ADDR, 8'h08 | 8'(g));
    end
    wr(`GAIN_POL_ADDR, 8'h00);
    chk("burnout", 24'h0, 24'(burnout));
    $display("Test gain done");
  endtask

  // Update must pulse exactly once for each write, both signs
  task automatic test_dac();
    int pulses;
    logic [7:0] codes [2] = '{8'h85, 8'h7f};
    for (int i = 0; i < 2; i++) begin
      pulses = 0;
      @(negedge clk);
      sfr_addr = `DAC_ADDR;
      sfr_wdata = codes[i];
      sfr_wr = 1'b1;
      repeat (3) begin
        @(negedge clk);
        sfr_wr = 1'b0;
        pulses += int'(dac_upd === 1'b1);
      end
      chk("dac pulses", 24'h1, 24'(pulses));
      chk("dac sign", 24'(codes[i][7]), 24'(dac_neg));
      chk("dac mag", 24'(codes[i][6:0]), 24'(dac_mag));
      rchk("dac reg", `DAC_ADDR, codes[i]);
    end
    $display("Test dac done");
  endtask

  task automatic test_cal();
    @(negedge clk);
    cal_limit_error = 1'b1;
    @(negedge clk);
    cal_limit_error = 1'b0;
    rchk("status", `ERR_STAT_ADDR, 8'h10);
    wr(`ERR_STAT_ADDR, 8'h00);
    rchk("status", `ERR_STAT_ADDR, 8'h00);
    $display("Test cal done");
  endtask

  // One single conversion; select 1 ends on the quick result, 0 on the slow
  task automatic single(input logic sel, input int per, input logic [23:0] s,
                        input logic [23:0] q);
    slow_filter_data = s;
    quick_filter_data = q;
    wr(`CONV_CFG_ADDR, {3'b000, sel, 4'h0});
    wr(`MODE_ADDR, 8'h01);
    chk("busy", 24'h1, 24'({busy, mod_run} == 2'b11));
    wait_for(1'b1, 4 * P + 8, n);
    // Done lands exactly at the end of the selected filter's last period
    chk("latency", 24'(per * P), 24'(n));
    repeat (3) @(negedge clk);
    chk("busy", 24'h0, 24'(busy));
    rchk("mode", `MODE_ADDR, 8'h00);
    rchk("slow hi", `SLOW_HIGH_ADDR, s[23:16]);
    rchk("slow mid", `SLOW_MID_ADDR, s[15:8]);
    rchk("slow lo", `SLOW_LOW_ADDR, s[7:0]);
    rchk("quick hi", `QUICK_HIGH_ADDR, q[23:16]);
    rchk("quick mid", `QUICK_MID_ADDR, q[15:8]);
    rchk("quick lo", `QUICK_LOW_ADDR, q[7:0]);
    wr(`ERR_STAT_ADDR, 8'h00);
  endtask

  // Back to back conversions with unread done, clips, refused config change
  task automatic test_continuous();
    quick_filter_data = 24'h000010;
    wr(`CONV_CFG_ADDR, 8'h10);
    wr(`MODE_ADDR, 8'h02);
    @(negedge clk);
    slow_filter_ovf = 1'b1;
    quick_filter_ovf = 1'b1;
    @(negedge clk);
    slow_filter_ovf = 1'b0;
    quick_filter_ovf = 1'b0;
    wait_for(1'b1, 2 * P + 4, n);
    quick_filter_data = 24'h000001;
    // First slow result falls at the end of the third period, after this change
    slow_filter_data = 24'h123456;
    wr(`GAIN_POL_ADDR, 8'h07);
    wr(`CONV_CFG_ADDR, 8'h00);
    repeat (P + 2) @(negedge clk);
    rchk("status", `ERR_STAT_ADDR, 8'hd7);
    rchk("quick lo", `QUICK_LOW_ADDR, 8'h01);
    rchk("slow lo", `SLOW_LOW_ADDR, 8'h56);
    rchk("gain reg", `GAIN_POL_ADDR, 8'h10);
    rchk("config", `CONV_CFG_ADDR, 8'h10);
    wr(`MODE_ADDR, 8'h00);
    wait_for(1'b0, P + 4, n);
    chk("run", 24'h0, 24'(mod_run));
    // Ones keep a flag: only done is cleared here
    wr(`ERR_STAT_ADDR, 8'h07);
    rchk("status", `ERR_STAT_ADDR, 8'h17);
    wr(`ERR_STAT_ADDR, 8'h00);
    rchk("status", `ERR_STAT_ADDR, 8'h00);
    $display("Test continuous done");
  endtask

  initial begin
    repeat (8) @(negedge clk);
    reset = 1'b0;
    test_reset();
    test_gain();
    test_dac();
    test_cal();
    single(1'b1, 1, 24'h000000, 24'h800000);
    $display("Test single quick done");
    wr(`GAIN_POL_ADDR, 8'h10);
    single(1'b0, 3, 24'hc00000, 24'h400000);
    $display("Test single slow done");
    test_continuous();
    finish_test();
  end
endmodule  // conv_control_test
